// [design/sep_pkg.sv]
// Purpose: Shared constants, types and helpers for the SPI EEPROM front end.
// Assumes: Core clock 25 MHz; link clock is the serial clock from the master.
// Notes:   Overview list below gives each behaviour on one line.
//
// Overview of operation
// - Output bits change on falling clock, MSB first, only in reads; else floating.
// - Input bits sampled on rising clock edge, MSB first.
// - Select low starts a frame; select high floats output at once.
// - Master uses mode 0/0 or 1/1; device behaves the same in both.
// - Hold low with clock low pauses; output floats, clock and input ignored.
// - Hold high with clock low resumes; bit position is kept.
// - Select rising during pause abandons the paused transfer.
// - After power-up, nothing starts until a falling select edge is seen.
// - Write runs only with latch set, whole bytes, data byte, aligned end.
// - Write dropped when select rises off a byte boundary.
// - Reads keep shifting data out until select rises.
// - Status bits six, five and four always read zero.
// - Busy flag is one during the internal write cycle, else zero.
// - With latch clear, write commands are decoded but not executed.
// - Set-latch command sets it; clear command, write end, power-up clear it.
// - Block-protect bits are non-volatile, changed only by unblocked status write.
// - Protect code 01 upper quarter, 10 upper half, 11 all plus ID page.
// - Disable bit zero: status writes accepted whatever the protect pin.
// - Disable bit one and protect pin low: status writes discarded.
// - Frozen state entered in either order, left only by protect pin high.
// - Status write changes only disable bit and the two protect bits.
// - Status register readable any time, repeated while select stays low.
package sep_pkg;

  // Core clock and timing
  localparam int CLK_PERIOD_NS = 40;

  // Instruction codes
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_SR_RD   = 8'h05;
  localparam logic [7:0] OP_SR_WR   = 8'h01;
  localparam logic [7:0] OP_ARR_RD  = 8'h03;
  localparam logic [7:0] OP_ARR_WR  = 8'h02;
  localparam logic [7:0] OP_ID_RD   = 8'h83;
  localparam logic [7:0] OP_ID_WR   = 8'h82;

  // Status byte layout
  localparam int SR_BUSY_BIT  = 0;
  localparam int SR_WEL_BIT   = 1;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_BP_HI_BIT = 3;
  localparam int SR_SWD_BIT   = 7;

  // Block-protect codes and bounds
  localparam logic [1:0]  BP_NONE      = 2'h0;
  localparam logic [1:0]  BP_QUARTER   = 2'h1;
  localparam logic [1:0]  BP_HALF      = 2'h2;
  localparam logic [1:0]  BP_ALL       = 2'h3;
  localparam logic [15:0] QUARTER_BASE = 16'hc000;
  localparam logic [15:0] HALF_BASE    = 16'h8000;

  // Frame byte counts
  localparam logic [2:0] BYTES_CMD    = 3'h1;
  localparam logic [2:0] BYTES_SR_WR  = 3'h2;
  localparam logic [2:0] BYTES_ADDR   = 3'h2;
  localparam logic [2:0] BYTES_ARR_WR = 3'h4;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [7:0] FILL_BYTE    = 8'hff;

  // Write cycle states and pending work
  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_CYCLE = 2'b10} sep_wstate_t;
  typedef enum logic [2:0] {
    PEND_NONE = 3'b001,
    PEND_SR   = 3'b010,
    PEND_ARR  = 3'b100
  } sep_pend_t;

  // status byte assembly, reserved bits zero
  function automatic logic [7:0] sep_sr_byte(input logic       swd,
                                             input logic [1:0] bp,
                                             input logic       write_enable_latch,
                                             input logic       busy);
    logic [7:0] r;
    r = 8'h00;
    r[SR_SWD_BIT]   = swd;
    r[SR_BP_HI_BIT] = bp[1];
    r[SR_BP_LO_BIT] = bp[0];
    r[SR_WEL_BIT]   = write_enable_latch;
    r[SR_BUSY_BIT]  = busy;
    return r;
  endfunction

  function automatic logic sep_is_protected(input logic [1:0]  bp,
                                            input logic [15:0] addr,
                                            input logic        id_page);
    logic p;
    p = 1'b0;
    if (id_page) begin
      p = (bp == BP_ALL);
    end else if (bp == BP_QUARTER) begin
      p = (addr >= QUARTER_BASE);
    end else if (bp == BP_HALF) begin
      p = (addr >= HALF_BASE);
    end else if (bp == BP_ALL) begin
      p = 1'b1;
    end
    return p;
  endfunction

endpackage

// [design/sep_out_if.sv]
// Purpose: Carries the serial output bit between the shifter and the pin stage.
// Assumes: Both ends live in the link clock domain.
// Notes:   The pin stage owns the output flip-flops.
`timescale 1ns/100ps
interface sep_out_if;
  logic out_bit;
  logic drive;
  logic so;
  logic so_oe;
  modport ctrl  (output out_bit, output drive, input so, input so_oe);
  modport stage (input out_bit, input drive, output so, output so_oe);
endinterface

// [design/sep_sync2.sv]
// Purpose: Two flip-flop level synchroniser.
// Assumes: Each bit is an independent level.
// Notes:   First stage is read only by the second.
`timescale 1ns/100ps
module sep_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sep_sy_t;

  sep_sy_t st_r;
  sep_sy_t st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("sep_sync2 WIDTH must be at least 1");
  end

  // Shift through two stages
  always_comb begin
    st_nxt.meta = d_i;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.sync;
endmodule

// [design/sep_out_stage.sv]
// Purpose: Drives the serial output pin on the falling serial clock.
// Assumes: Select high or reset floats the pin without a clock edge.
// Notes:   Hold low floats the pin from the next falling edge.
`timescale 1ns/100ps
module sep_out_stage (
  // Link clock and resets
  input  wire logic  sck_i,
  input  wire logic  rst_n_i,
  input  wire logic  cs_n_i,
  // Pause pin
  input  wire logic  hold_n_i,
  // Shifter side
  sep_out_if.stage   oif
);
  typedef struct packed {
    logic so;
    logic so_oe;
  } sep_os_t;

  sep_os_t st_r;
  sep_os_t st_nxt;

  always_comb begin
    st_nxt.so    = oif.out_bit;
    st_nxt.so_oe = oif.drive & hold_n_i;
  end

  always_ff @(negedge sck_i or negedge rst_n_i or posedge cs_n_i) begin
    if (!rst_n_i || cs_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign oif.so    = st_r.so;
  assign oif.so_oe = st_r.so_oe;
endmodule

// [design/sep_eeprom_front.sv]
// Purpose: SPI front end of a byte EEPROM: framing, hold, status, write guards.
// Assumes: Select stays high at least three core clocks between frames.
// Notes:   Array data path is absent; reads return a fill byte.
`timescale 1ns/100ps
module sep_eeprom_front
  import sep_pkg::*;
#(
  parameter int         WCYC_US  = 5000,
  parameter logic       SWD_INIT = 1'b0,
  parameter logic [1:0] BP_INIT  = 2'h0
) (
  // Core clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Serial link
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  output logic      so_o,
  output logic      so_oe_o,
  // Protect pin
  input  wire logic wp_n_i
);

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int TW_CYC = (WCYC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW_W   = $clog2(TW_CYC + 1);

  if (TW_CYC < 8) begin : g_bad_tw
    $error("sep_eeprom_front write cycle must be at least 8 core clocks");
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain state
  typedef struct packed {
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [6:0]  in_sr;
    logic [7:0]  op;
    logic [15:0] addr;
    logic [7:0]  out_sr;
    logic        rd_on;
    logic        frame_tog;
  } sep_lk_t;

  // Core domain state
  typedef struct packed {
    logic        cs_q;
    logic        started;
    logic        seen_tog;
    sep_wstate_t ws;
    logic [TW_W-1:0] tw_cnt;
    sep_pend_t   pend;
    logic        write_enable_latch;
    logic        swd;
    logic [1:0]  bp;
    logic        nswd;
    logic [1:0]  nbp;
  } sep_ck_t;

  sep_lk_t    lk_r;
  sep_lk_t    lk_nxt;
  sep_ck_t    ck_r;
  sep_ck_t    ck_nxt;
  logic       first_r;
  logic       armed_r;
  logic [4:0] sr_lk;
  logic [2:0] pins_s;
  logic       cs_s;
  logic       hold_s;
  logic       wp_s;
  logic       busy;
  logic       rise;
  logic       frame_ok;
  logic [7:0] nb;

  sep_out_if oif ();

  ////////////////////////////////////////////////////////////////////////
  // Link domain: frame start flags
  // armed only after select was seen high
  // Select high rearms the frame start
  always_ff @(posedge sck_i or negedge rst_n_i or posedge cs_n_i) begin
    if (!rst_n_i) begin
      first_r <= 1'b1;
      armed_r <= 1'b0;
    end else if (cs_n_i) begin
      first_r <= 1'b1;
      armed_r <= 1'b1;
    end else if (hold_n_i) begin
      first_r <= 1'b0;
    end
  end

  // Status snapshot into the link domain
  sep_sync2 #(.WIDTH(5)) u_sr_sync (
    .clk_i   (sck_i),
    .rst_n_i (rst_n_i),
    .d_i     ({ck_r.swd, ck_r.bp, ck_r.write_enable_latch, busy}),
    .q_o     (sr_lk)
  );

  // Shifter next state
  always_comb begin
    logic [2:0] bc;
    logic [2:0] byc;
    logic       rd;
    bc     = first_r ? 3'h0 : lk_r.bit_cnt;
    byc    = first_r ? 3'h0 : lk_r.byte_cnt;
    rd     = first_r ? 1'b0 : lk_r.rd_on;
    nb     = {lk_r.in_sr, si_i};
    lk_nxt = lk_r;
    if (hold_n_i) begin
      lk_nxt.in_sr    = nb[6:0];
      lk_nxt.bit_cnt  = bc + 3'h1;
      lk_nxt.byte_cnt = byc;
      lk_nxt.rd_on    = rd;
      lk_nxt.out_sr   = {lk_r.out_sr[6:0], 1'b0};
      if (first_r) begin
        lk_nxt.frame_tog = ~lk_r.frame_tog;
      end
      if (bc == BIT_LAST) begin
        if (byc != BYTES_ARR_WR) begin
          lk_nxt.byte_cnt = byc + 3'h1;
        end
        if (byc == 3'h0) begin
          lk_nxt.op = nb;
        end else if (byc == 3'h1) begin
          lk_nxt.addr[15:8] = nb;
        end else if (byc == 3'h2) begin
          lk_nxt.addr[7:0] = nb;
        end
        if (armed_r && byc == 3'h0 && nb == OP_SR_RD) begin
          lk_nxt.rd_on  = 1'b1;
          lk_nxt.out_sr = sep_sr_byte(sr_lk[4], sr_lk[3:2], sr_lk[1], sr_lk[0]);
        end else if (rd && lk_r.op == OP_SR_RD) begin
          lk_nxt.out_sr = sep_sr_byte(sr_lk[4], sr_lk[3:2], sr_lk[1], sr_lk[0]);
        end else if (armed_r && byc == BYTES_ADDR && !sr_lk[0]
                     && (lk_r.op == OP_ARR_RD || lk_r.op == OP_ID_RD)) begin
          lk_nxt.rd_on  = 1'b1;
          lk_nxt.out_sr = FILL_BYTE;
        end else if (rd) begin
          lk_nxt.out_sr = FILL_BYTE;
        end
      end
    end
  end

  // same rising-edge sampling in both modes
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk_r <= '0;
    end else if (!cs_n_i) begin
      lk_r <= lk_nxt;
    end
  end

  assign oif.out_bit = lk_r.out_sr[7];
  assign oif.drive   = lk_r.rd_on & ~first_r;

  sep_out_stage u_out (
    .sck_i    (sck_i),
    .rst_n_i  (rst_n_i),
    .cs_n_i   (cs_n_i),
    .hold_n_i (hold_n_i),
    .oif      (oif)
  );

  assign so_o    = oif.so;
  assign so_oe_o = oif.so_oe;

  ////////////////////////////////////////////////////////////////////////
  // Core domain
  sep_sync2 #(.WIDTH(3)) u_pin_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({cs_n_i, hold_n_i, wp_n_i}),
    .q_o     (pins_s)
  );
  assign cs_s   = pins_s[2];
  assign hold_s = pins_s[1];
  assign wp_s   = pins_s[0];
  assign busy = (ck_r.ws == WS_CYCLE);
  assign rise = cs_s & ~ck_r.cs_q;

  // whole bytes, clean start, edges seen
  // select rising while paused drops the frame
  assign frame_ok = ck_r.started && hold_s && (lk_r.frame_tog != ck_r.seen_tog)
                    && (lk_r.bit_cnt == 3'h0) && (lk_r.byte_cnt >= BYTES_CMD);

  // Command acceptance and write cycle
  always_comb begin
    ck_nxt      = ck_r;
    ck_nxt.cs_q = cs_s;
    // only a seen falling edge starts a frame
    if (ck_r.cs_q && !cs_s) begin
      ck_nxt.started = 1'b1;
    end
    if (ck_r.ws == WS_CYCLE) begin
      if (ck_r.tw_cnt == TW_W'(1)) begin
        ck_nxt.ws     = WS_IDLE;
        ck_nxt.tw_cnt = '0;
        ck_nxt.write_enable_latch    = 1'b0;
        // only disable and protect bits move
        if (ck_r.pend == PEND_SR) begin
          ck_nxt.swd = ck_r.nswd;
          ck_nxt.bp  = ck_r.nbp;
        end
        ck_nxt.pend = PEND_NONE;
      end else begin
        ck_nxt.tw_cnt = ck_r.tw_cnt - TW_W'(1);
      end
    end
    if (rise) begin
      ck_nxt.started  = 1'b0;
      ck_nxt.seen_tog = lk_r.frame_tog;
      if (frame_ok) begin
        if (lk_r.op == OP_CLR_WEL) begin
          ck_nxt.write_enable_latch = 1'b0;
        end else if (lk_r.op == OP_SET_WEL && !busy) begin
          ck_nxt.write_enable_latch = 1'b1;
        end else if (lk_r.op == OP_SR_WR && !busy && ck_r.write_enable_latch
                     && lk_r.byte_cnt >= BYTES_SR_WR && !(ck_r.swd && !wp_s)) begin
          ck_nxt.ws     = WS_CYCLE;
          ck_nxt.tw_cnt = TW_W'(TW_CYC);
          ck_nxt.pend   = PEND_SR;
          ck_nxt.nswd   = lk_r.addr[8 + SR_SWD_BIT];
          ck_nxt.nbp    = {lk_r.addr[8 + SR_BP_HI_BIT], lk_r.addr[8 + SR_BP_LO_BIT]};
        end else if ((lk_r.op == OP_ARR_WR || lk_r.op == OP_ID_WR) && !busy
                     && ck_r.write_enable_latch && lk_r.byte_cnt >= BYTES_ARR_WR
                     && !sep_is_protected(ck_r.bp, lk_r.addr, lk_r.op == OP_ID_WR)) begin
          ck_nxt.ws     = WS_CYCLE;
          ck_nxt.tw_cnt = TW_W'(TW_CYC);
          ck_nxt.pend   = PEND_ARR;
        end
      end
    end
  end

  // Core state register, latch clear at power-up
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ck_r          <= '0;
      ck_r.ws       <= WS_IDLE;
      ck_r.pend     <= PEND_NONE;
      ck_r.swd      <= SWD_INIT;
      ck_r.bp       <= BP_INIT;
    end else begin
      ck_r <= ck_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core assertions
  a_wel_set_cmd: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && frame_ok && lk_r.op == OP_SET_WEL && !busy) |=> ck_r.write_enable_latch)
    else $error("latch not set by set command");

  a_wel_clr_cmd: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && frame_ok && lk_r.op == OP_CLR_WEL) |=> !ck_r.write_enable_latch)
    else $error("latch not cleared by clear command");

  a_cycle_end_wel: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(busy) |-> !ck_r.write_enable_latch)
    else $error("latch still set after write cycle");

  a_busy_min_len: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(busy) |-> busy[*8])
    else $error("busy dropped too early");

  a_frozen_status: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && lk_r.op == OP_SR_WR && ck_r.swd && !wp_s && !busy) |=> !busy)
    else $error("status write ran while frozen");

  a_partial_drop: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && lk_r.bit_cnt != 3'h0 && !busy) |=> !busy && $stable(ck_r.write_enable_latch))
    else $error("misaligned frame was executed");

  a_no_latch_exec: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && !ck_r.write_enable_latch && !busy) |=> !busy)
    else $error("write ran with latch clear");

  a_protect_all: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && lk_r.op == OP_ARR_WR && ck_r.bp == BP_ALL && !busy) |=> !busy)
    else $error("write into fully protected array");

  a_sr_update: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (busy && ck_r.pend == PEND_SR && ck_r.tw_cnt == TW_W'(1))
    |=> ck_r.swd == $past(ck_r.nswd) && ck_r.bp == $past(ck_r.nbp))
    else $error("status fields not updated at cycle end");

  a_no_start_unsel: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && !ck_r.started && !busy) |=> !busy)
    else $error("frame without falling select was executed");

  a_paused_drop: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rise && !hold_s && !busy) |=> !busy && $stable(ck_r.write_enable_latch))
    else $error("paused frame was executed");

  a_float_desel: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (cs_s && ck_r.cs_q) |-> !so_oe_o)
    else $error("output driven while deselected");

  ////////////////////////////////////////////////////////////////////////
  // Link assertions
  a_sample_count: assert property (
    @(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (hold_n_i && !first_r) |=> lk_r.bit_cnt == $past(lk_r.bit_cnt) + 3'h1)
    else $error("bit count did not advance on rising edge");

  a_hold_freeze: assert property (
    @(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    !hold_n_i |=> $stable(lk_r))
    else $error("shifter moved while paused");

  a_rsvd_zero: assert property (
    @(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (lk_r.rd_on && lk_r.op == OP_SR_RD && lk_r.bit_cnt == 3'h0 && !first_r)
    |-> lk_r.out_sr[6:4] == 3'h0)
    else $error("reserved status bits not zero");

endmodule

// [verification/sep_spi_master.sv]
// Purpose: SPI bus master model facing the EEPROM front end.
// Assumes: Serial clock period 32 ns, running only inside frames.
// Notes:   A released output line shows the inverse of its last level.
`timescale 1ns/100ps
module sep_spi_master (
  // Core clock for frame timing
  input  wire logic clk_i,
  // Device output
  input  wire logic so_i,
  input  wire logic so_oe_i,
  // Link drive
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o
);
  logic cpol;
  logic oe_any;
  logic oe_hold;
  logic so_last;
  logic so_line;

  ////////////////////////////////////////
  // Power-up levels, select already low
  initial begin
    sck_o    = 1'b0;
    cs_n_o   = 1'b0;
    si_o     = 1'b0;
    hold_n_o = 1'b1;
    cpol     = 1'b0;
    so_last  = 1'b0;
  end

  // Floating line never repeats the last bit
  assign so_line = so_oe_i ? so_i : ~so_last;
  always @(posedge sck_o) if (so_oe_i) so_last <= so_i;

  ////////////////////////////////////////
  // idle level set between frames
  task automatic set_mode(input logic m);
    @(posedge clk_i);
    cpol = m;
    sck_o <= m;
  endtask

  task automatic pause(input logic abort);
    int k;
    #8 hold_n_o <= 1'b0;
    for (k = 0; k < 2; k++) begin
      #8 si_o <= ~si_o;
      sck_o <= 1'b1;
      #16 sck_o <= 1'b0;
    end
    #8 oe_hold = so_oe_i;
    if (abort) begin
      @(posedge clk_i) cs_n_o <= 1'b1;
      @(posedge clk_i) hold_n_o <= 1'b1;
    end else begin
      hold_n_o <= 1'b1;
      #16;
    end
  endtask

  // One framed transfer, MSB first, sampled before each rise
  task automatic xfer(input logic [39:0] tx, input int nbits, input int hold_at,
                      input logic abort, output logic [39:0] rx);
    int i;
    rx = '0;
    oe_any = 1'b0;
    @(posedge clk_i) cs_n_o <= 1'b0;
    #4;
    for (i = 0; i <= nbits; i++) begin
      sck_o <= (i == nbits) ? cpol : 1'b0;
      if (i == hold_at) begin
        pause(abort);
      end
      if (i == nbits || (abort && i == hold_at)) begin
        break;
      end
      si_o <= tx[nbits-1-i];
      #16;
      rx = {rx[38:0], so_line};
      oe_any = oe_any | so_oe_i;
      sck_o <= 1'b1;
      #16;
    end
    #16;
    @(posedge clk_i) cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// [verification/tb_spi_eeprom_protocol_and_protection.sv]
// Purpose: Self-checking bench for the SPI EEPROM front end.
// Assumes: Write cycle shortened to 25 core clocks.
// Notes:   Status expectations are written here as whole hex bytes.
`timescale 1ns/100ps
module tb_spi_eeprom_protocol_and_protection;
  import sep_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic        wp_n;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        hold_n;
  logic        so;
  logic        so_oe;
  logic        prot;
  logic [39:0] rx;
  logic [7:0]  sr;
  logic [15:0] addrs [4] = '{16'h7fff, 16'h8000, 16'hbfff, 16'hc000};
  int          n_mismatch;
  int          compares;
  int          b;
  int          a;

  ////////////////////////////////////////
  // Device and master
  sep_eeprom_front #(.WCYC_US(1), .SWD_INIT(1'b0), .BP_INIT(2'h0)) sep_eeprom_front_i (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n));
  sep_spi_master sep_spi_master_i (.clk_i(core_clk), .so_i(so), .so_oe_i(so_oe),
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));

  ////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Non-read frame, output must stay off
  task automatic frame(input logic [39:0] tx, input int nbits);
    sep_spi_master_i.xfer(tx, nbits, -1, 1'b0, rx);
    chk(sep_spi_master_i.oe_any, 1'b0);
  endtask

  // Status read, second byte repeats the first
  task automatic rd_sr(output logic [7:0] v);
    sep_spi_master_i.xfer({8'h05, 16'h0}, 24, -1, 1'b0, rx);
    chk((rx[7:0] == rx[15:8]) || (rx[8] && !rx[0]), 1'b1);
    chk(rx[14:12], 3'h0);
    v = rx[15:8];
  endtask

  task automatic exp_sr(input logic [7:0] e);
    rd_sr(sr);
    chk(sr, e);
  endtask

  task automatic sr_wr(input logic [7:0] d);
    frame(40'h06, 8);
    frame({8'h01, d}, 16);
  endtask

  // Poll until the write cycle ends
  task automatic wait_ready();
    int k;
    for (k = 0; k < 10; k++) begin
      rd_sr(sr);
      if (sr[0] === 1'b0) break;
    end
  endtask

  ////////////////////////////////////////
  // Clock, watchdog, deselect monitor
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end

  always @(posedge cs_n) begin
    #2;
    chk(so_oe, 1'b0);
  end

  ////////////////////////////////////////
  // Test sequence
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Select low since power-up
    frame(40'h06, 8);
    exp_sr(8'h00);
    for (b = 0; b < 2; b++) begin
      sep_spi_master_i.set_mode(b[0]);
      frame(40'h06, 8);
      exp_sr(8'h02);
      frame(40'h04, 8);
      exp_sr(8'h00);
      frame({8'h01, 8'h8c}, 16);
      exp_sr(8'h00);
    end
    sep_spi_master_i.set_mode(1'b0);
    frame(40'h06, 8);
    frame({8'h01, 7'h46}, 15);
    frame({8'h01, 8'h8c, 1'b0}, 17);
    exp_sr(8'h02);
    frame({8'h01, 8'hff}, 16);
    exp_sr(8'h03);
    wait_ready();
    exp_sr(8'h8c);
    wp_n <= 1'b0;
    sr_wr(8'h00);
    exp_sr(8'h8e);
    frame(40'h04, 8);
    wp_n <= 1'b1;
    sr_wr(8'h04);
    wait_ready();
    exp_sr(8'h04);
    wp_n <= 1'b0;
    sr_wr(8'h80);
    wait_ready();
    exp_sr(8'h80);
    sr_wr(8'h00);
    exp_sr(8'h82);
    wp_n <= 1'b1;
    // Every protect code against boundary addresses and the ID page
    for (b = 0; b < 4; b++) begin
      sr_wr({4'h0, b[1:0], 2'h0});
      wait_ready();
      for (a = 0; a < 5; a++) begin
        frame(40'h06, 8);
        if (a < 4) frame({8'h02, addrs[a], 8'h5a}, 32);
        else frame({8'h82, 16'h0000, 8'h5a}, 32);
        prot = (b == 3) || (a < 4 && ((b == 1 && a == 3) || (b == 2 && a >= 1)));
        rd_sr(sr);
        chk(sr[0], !prot);
        wait_ready();
      end
    end
    // Pause inside an instruction, then abandon a paused write
    frame(40'h04, 8);
    sep_spi_master_i.xfer(40'h06, 8, 4, 1'b0, rx);
    exp_sr(8'h0e);
    sep_spi_master_i.xfer({8'h01, 8'h00}, 16, 16, 1'b1, rx);
    exp_sr(8'h0e);
    sep_spi_master_i.xfer({8'h05, 16'h0}, 24, 20, 1'b0, rx);
    chk(rx[15:8], 8'h0e);
    chk(sep_spi_master_i.oe_hold, 1'b0);
    sep_spi_master_i.xfer({8'h03, 32'h0}, 40, -1, 1'b0, rx);
    chk(rx[15:0], 16'hffff);
    sep_spi_master_i.xfer({8'h83, 32'h0}, 40, -1, 1'b0, rx);
    chk(rx[15:0], 16'hffff);
    complete_run();
  end
endmodule
